//--- ssm_pkg.sv
/*
 * Constants, types and register map shared by the safety stop monitor.
 * Assumes a single 250 MHz system clock and an APB register bus.
 */
package ssm_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 250;
    localparam int FILTER_US = 2000;
    localparam int FILTER_CYCLES = FILTER_US * CLK_MHZ;
    localparam int CNT_W = 20;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_SEL0 = 12'h004;
    localparam logic [11:0] ADDR_SEL1 = 12'h008;
    localparam logic [11:0] ADDR_SEL2 = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    // CTRL fields
    localparam int CTRL_FAULT_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;

    // ==========================================================
    // Terminal selection codes, 9 bits to hold 181
    // ==========================================================
    localparam int SEL_W = 9;
    localparam logic [8:0] SEL_RUNNING = 9'h000;
    localparam logic [8:0] SEL_FREQ_DET = 9'h001;
    localparam logic [8:0] SEL_SAFE_POS = 9'h050;
    localparam logic [8:0] SEL_SAFE_NEG = 9'h0b4;
    localparam logic [8:0] SEL_HEALTH_POS = 9'h051;
    localparam logic [8:0] SEL_HEALTH_NEG = 9'h0b5;
    localparam logic [8:0] SEL0_RESET = SEL_RUNNING;
    localparam logic [8:0] SEL1_RESET = SEL_FREQ_DET;
    localparam logic [8:0] SEL2_RESET = SEL_RUNNING;

    // ==========================================================
    // Fault display codes
    // ==========================================================
    typedef enum logic [2:0] {
        SSM_DISP_NONE,
        SSM_DISP_STOP_ACTIVE,
        SSM_DISP_SAFETY_FAULT,
        SSM_DISP_FAULT_6,
        SSM_DISP_FAULT_7,
        SSM_DISP_FAULT_CPU
    } ssm_disp_t;

endpackage : ssm_pkg

//--- ssm_filter.sv
/*
 * One stop-channel input filter: three-flop synchroniser then a
 * stability counter. Assumes an asynchronous pin input.
 */
module ssm_filter #(
    parameter int CYCLES = ssm_pkg::FILTER_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic pinIn,
    output logic level
);
    import ssm_pkg::*;

    logic sync1_q, sync2_q, sync3_q;
    logic [CNT_W-1:0] cnt_q;
    logic level_q;
    wire agree = (sync2_q == sync3_q);
    wire differ = agree && (sync3_q != level_q);
    wire expired = (cnt_q == CNT_W'(CYCLES - 1));

    // ==========================================================
    // Synchroniser, open (low) at reset so drive starts off
    // ==========================================================
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ==========================================================
    // Level accepted only after it stands the full window
    // ==========================================================
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end else if (!differ) begin
            cnt_q <= '0; // see R1
        end else if (expired) begin
            cnt_q <= '0;
            level_q <= sync3_q; // see R1
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign level = level_q;

    filter_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R1
        $changed(level_q) |-> $past(differ) && $past(expired))
        else $error("filtered level changed early");

endmodule : ssm_filter

//--- ssm_out_mux.sv
/*
 * One output-terminal selector: maps a selection code onto safe-state,
 * health or a default signal, in either polarity.
 */
module ssm_out_mux (
    input wire logic [ssm_pkg::SEL_W-1:0] sel,
    input wire logic safeState,
    input wire logic health,
    input wire logic running,
    input wire logic freqDetect,
    output logic termOn
);
    import ssm_pkg::*;

    always_comb begin
        unique case (sel)
            SEL_SAFE_POS: termOn = safeState; // see R8
            SEL_SAFE_NEG: termOn = !safeState; // see R8
            SEL_HEALTH_POS: termOn = health; // see R9
            SEL_HEALTH_NEG: termOn = !health; // see R9
            SEL_FREQ_DET: termOn = freqDetect;
            default: termOn = running;
        endcase
    end

endmodule : ssm_out_mux

//--- ssm_monitor.sv
/*
 * Dual-channel safety stop monitor with APB registers and three
 * open-collector output terminals.
 * Assumes stop channels arrive asynchronously from a relay module,
 * powerGood from a supervisor, and APB on clk_sys.
 */
// Design decisions made here: the register offsets and register access over APB.
// How it works
// R1: Channel levels must hold 2ms; shorter pulses are ignored.
// R2: Open channel means safety stop request, drive shut off.
// R3: Drive enabled only with both shorted and no failure.
// R4: Safe-state on when both open and circuit healthy.
// R5: Health on whenever no internal failure exists.
// R6: Failure or channel mismatch shuts drive, clears both, shows fault code.
// R7: Stop-active indication shown when both open and healthy.
// R8: Code 80/180 routes safe-state to a terminal, second defaults frequency.
// R9: Code 81/181 routes health to a terminal, first defaults running.
// R10: Health on first terminal turns it off at a fault.
// R11: Outputs are open-collector transistors, conducting when on.
// R12: Without valid power, drive off and both status outputs off.
module ssm_monitor #(
    parameter int FILTER = ssm_pkg::FILTER_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic stopChannelOne,
    input wire logic stopChannelTwo,
    input wire logic powerGood,
    input wire logic internalFault,
    input wire logic motorRunning,
    input wire logic freqDetect,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic driveEnable,
    output logic safeState,
    output logic safetyHealthFlag,
    output logic [2:0] terminalOn,
    output ssm_pkg::ssm_disp_t display
);
    import ssm_pkg::*;

    // ==========================================================
    // Input filtering
    // ==========================================================
    logic chOne, chTwo;
    logic [1:0] chLevel;
    logic pg1_q, pg2_q, pg3_q, pgood_q;
    wire [1:0] chPin = {stopChannelTwo, stopChannelOne};

    // Both channels filtered alike, so neither wins a race at a change
    for (genvar c = 0; c < 2; c++) begin : g_filt
        ssm_filter #(.CYCLES(FILTER)) u_filt (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .pinIn(chPin[c]),
            .level(chLevel[c])
        );
    end
    assign chOne = chLevel[0];
    assign chTwo = chLevel[1];

    // Power good also passes three flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pg1_q <= 1'b0;
            pg2_q <= 1'b0;
            pg3_q <= 1'b0;
            pgood_q <= 1'b0;
        end else begin
            pg1_q <= powerGood;
            pg2_q <= pg1_q;
            pg3_q <= pg2_q;
            if (pg2_q == pg3_q) begin
                pgood_q <= pg3_q;
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    logic [SEL_W-1:0] sel_q [3];
    logic swFault_q;
    logic latchedFault_q;
    logic if1_q, if2_q, if3_q, ifault_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            if1_q <= 1'b0;
            if2_q <= 1'b0;
            if3_q <= 1'b0;
            ifault_q <= 1'b0;
        end else begin
            if1_q <= internalFault;
            if2_q <= if1_q;
            if3_q <= if2_q;
            if (if2_q == if3_q) begin
                ifault_q <= if3_q;
            end
        end
    end

    wire access = psel && penable;
    // Writes land only on the completing edge, as the master sees pready
    wire wrEn = access && pwrite && pready;
    wire hitCtrl = (paddr == ADDR_CTRL);
    wire hitStat = (paddr == ADDR_STATUS);
    // Wraps to 3 when paddr[3:2] is 0, as at CTRL and STATUS; used only under hitSel
    wire [1:0] selIdx = paddr[3:2] - 2'd1;
    wire hitSel = (paddr == ADDR_SEL0) || (paddr == ADDR_SEL1) || (paddr == ADDR_SEL2);
    wire mapped = hitCtrl || hitStat || hitSel;
    wire clearReq = wrEn && hitCtrl && pstrb[0] && pwdata[CTRL_CLEAR_BIT];

    // Mismatch counts as a failure and latches until cleared
    wire mismatch = chOne ^ chTwo; // see R6
    wire faultNow = ifault_q || swFault_q || mismatch;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_q[0] <= SEL0_RESET; // see R9
            sel_q[1] <= SEL1_RESET; // see R8
            sel_q[2] <= SEL2_RESET;
            swFault_q <= 1'b0;
        end else if (wrEn && pstrb[0]) begin
            if (hitSel) begin
                sel_q[selIdx] <= {pstrb[1] ? pwdata[8] : sel_q[selIdx][8], pwdata[7:0]};
            end
            if (hitCtrl) begin
                swFault_q <= pwdata[CTRL_FAULT_BIT];
            end
        end
    end

    // Set wins over clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latchedFault_q <= 1'b0;
        end else if (faultNow) begin
            latchedFault_q <= 1'b1; // see R6
        end else if (clearReq) begin
            latchedFault_q <= 1'b0;
        end
    end

    // ==========================================================
    // Decision logic
    // ==========================================================
    wire failure = faultNow || latchedFault_q;
    wire bothShort = chOne && chTwo;
    wire bothOpen = !chOne && !chTwo;
    // Open channel never enables, so an open line is a stop request
    wire enNext = pgood_q && bothShort && !failure; // see R2 // see R3 // see R12
    wire safeNext = pgood_q && bothOpen && !failure; // see R4 // see R6 // see R12
    wire healthNext = pgood_q && !failure; // see R5 // see R6 // see R12
    ssm_disp_t dispNext;
    logic [2:0] termNext;

    always_comb begin
        if (!pgood_q) begin
            dispNext = SSM_DISP_NONE;
        end else if (ifault_q) begin
            dispNext = SSM_DISP_FAULT_CPU; // see R6
        end else if (swFault_q) begin
            dispNext = SSM_DISP_FAULT_6;
        end else if (mismatch) begin
            dispNext = SSM_DISP_FAULT_7;
        end else if (latchedFault_q) begin
            dispNext = SSM_DISP_SAFETY_FAULT;
        end else if (bothOpen) begin
            dispNext = SSM_DISP_STOP_ACTIVE; // see R7
        end else begin
            dispNext = SSM_DISP_NONE;
        end
    end

    genvar t;
    generate
        for (t = 0; t < 3; t++) begin : g_term
            logic raw;
            ssm_out_mux u_mux (
                .sel(sel_q[t]),
                .safeState(safeNext),
                .health(healthNext), // see R10
                .running(motorRunning),
                .freqDetect(freqDetect),
                .termOn(raw)
            );
            // Terminals float off without power, whatever the polarity
            assign termNext[t] = pgood_q && raw; // see R11 // see R12
        end
    endgenerate

    // ==========================================================
    // Registered outputs
    // ==========================================================
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            driveEnable <= 1'b0;
            safeState <= 1'b0;
            safetyHealthFlag <= 1'b0;
            terminalOn <= '0;
            display <= SSM_DISP_NONE;
        end else begin
            driveEnable <= enNext;
            safeState <= safeNext;
            safetyHealthFlag <= healthNext;
            terminalOn <= termNext;
            display <= dispNext;
        end
    end

    // ==========================================================
    // APB answer: one wait state, unmapped answers pslverr
    // ==========================================================
    logic [31:0] rdNext;
    always_comb begin
        rdNext = '0;
        if (hitCtrl) begin
            rdNext[CTRL_FAULT_BIT] = swFault_q;
        end else if (hitSel) begin
            rdNext[SEL_W-1:0] = sel_q[selIdx];
        end else if (hitStat) begin
            rdNext[6:0] = {ssm_disp_t'(display), latchedFault_q, chTwo, chOne, pgood_q};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && !mapped;
            prdata <= (access && !pready && !pwrite) ? rdNext : '0;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    // Each check but stop_disp_a looks one edge after its cause, as every output is registered
    drive_both_short_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R3
        driveEnable |-> $past(chOne && chTwo && !failure && pgood_q))
        else $error("drive enabled without both channels shorted");
    drive_on_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R3
        (bothShort && !failure && pgood_q) |=> driveEnable)
        else $error("drive not enabled with both channels shorted");
    open_stops_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R2
        !chOne |=> !driveEnable)
        else $error("drive enabled with open channel");
    safe_state_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R4
        (bothOpen && !failure && pgood_q) |=> safeState)
        else $error("safe-state missing");
    health_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R5
        safetyHealthFlag == $past(pgood_q && !failure))
        else $error("health flag wrong");
    mismatch_fault_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R6
        (mismatch && pgood_q) |=> !safeState && !safetyHealthFlag && !driveEnable
            && display inside {SSM_DISP_FAULT_7, SSM_DISP_FAULT_CPU, SSM_DISP_FAULT_6})
        else $error("mismatch not handled as fault");
    fault_code_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R6
        (ifault_q && pgood_q) |=> display == SSM_DISP_FAULT_CPU && !driveEnable)
        else $error("internal failure code missing");
    stop_disp_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R7
        safeState |-> display == SSM_DISP_STOP_ACTIVE)
        else $error("stop indication missing");
    stop_show_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R7
        (bothOpen && !failure && pgood_q) |=> display == SSM_DISP_STOP_ACTIVE)
        else $error("stop indication not shown");
    sel_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R8
        (sel_q[2] == SEL_SAFE_NEG && pgood_q) |=> terminalOn[2] == !safeState)
        else $error("negative safe-state routing wrong");
    safe_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R8
        (sel_q[1] == SEL_SAFE_POS && pgood_q) |=> terminalOn[1] == safeState)
        else $error("positive safe-state routing wrong");
    health_route_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R9
        (sel_q[0] == SEL_HEALTH_POS && pgood_q) |=> terminalOn[0] == safetyHealthFlag)
        else $error("positive health routing wrong");
    health_term_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R10
        (sel_q[0] == SEL_HEALTH_POS && failure) |=> !terminalOn[0])
        else $error("first terminal on during fault");
    no_power_a: assert property (@(posedge clk_sys) disable iff (!resetn) // see R12
        !pgood_q |=> !driveEnable && !safeState && !safetyHealthFlag && terminalOn == 3'b000)
        else $error("outputs on without power");

    apb_answer_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (psel && penable && !pready) |=> pready)
        else $error("bus access not answered");

    drive_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn) driveEnable);
    route_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        sel_q[2] == SEL_SAFE_NEG && terminalOn[2]);
    stop_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn) safeState);
    mism_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn) mismatch ##1 latchedFault_q);
    clr_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        latchedFault_q ##1 !latchedFault_q);

endmodule : ssm_monitor

//--- ssm_relay_model.sv
/*
 * Behavioural safety relay module driving both stop channels.
 * Assumes the bench commands run, split and glitch requests on clk_sys.
 */
module ssm_relay_model #(
    parameter int HOLD = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic runReq,
    input wire logic splitReq,
    input wire logic glitchReq,
    output logic chOne,
    output logic chTwo
);
    // ==========================================================
    // Contact state
    // ==========================================================
    logic level_q;
    logic [7:0] age_q;
    logic [1:0] glitch_q;

    // Contacts never change again before HOLD cycles have passed
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            level_q <= 1'h0;
            age_q <= 8'h0;
            glitch_q <= 2'h0;
        end else begin
            glitch_q <= glitchReq ? 2'h2 : (glitch_q != 2'h0 ? glitch_q - 2'h1 : 2'h0);
            if (runReq != level_q && age_q >= 8'(HOLD)) begin
                level_q <= runReq;
                age_q <= 8'h0;
            end else if (age_q < 8'(HOLD)) begin
                age_q <= age_q + 8'h1;
            end
        end
    end

    // Split and glitch are faults only when the bench asks for them
    assign chOne = level_q & ~splitReq & (glitch_q == 2'h0);
    assign chTwo = level_q;
endmodule : ssm_relay_model

//--- tb_top.sv
/*
 * Self-checking bench for the safety stop monitor.
 * Assumes a short filter parameter and the relay model on the channels.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ssm_pkg::*;

    localparam int FILT = 8;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic runReq = 1'h0, splitReq = 1'h0, glitchReq = 1'h0;
    logic stopChannelOne, stopChannelTwo;
    logic powerGood = 1'h0, internalFault = 1'h0;
    logic motorRunning = 1'h1, freqDetect = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, rerr, driveEnable, safeState, safetyHealthFlag;
    logic [2:0] terminalOn;
    ssm_disp_t display;
    int numErrors = 0;
    int nTests = 0;

    always #2 clk_sys = ~clk_sys;

    ssm_relay_model #(.HOLD(2 * FILT)) i_relay (.clk_sys(clk_sys), .resetn(resetn),
        .runReq(runReq), .splitReq(splitReq), .glitchReq(glitchReq),
        .chOne(stopChannelOne), .chTwo(stopChannelTwo));

    ssm_monitor #(.FILTER(FILT)) i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .stopChannelOne(stopChannelOne), .stopChannelTwo(stopChannelTwo),
        .powerGood(powerGood), .internalFault(internalFault),
        .motorRunning(motorRunning), .freqDetect(freqDetect), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .driveEnable(driveEnable), .safeState(safeState),
        .safetyHealthFlag(safetyHealthFlag), .terminalOn(terminalOn),
        .display(display));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic results();
        if (numErrors == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; only the watchdog ends a wait for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'h0, a, 32'h0);
        chk(rdat, exp);
        chk({31'h0, rerr}, {31'h0, err});
    endtask : rd_chk

    // Filter latency plus relay hold time is well under this span
    task automatic settle();
        repeat (4 * FILT + 16) @(posedge clk_sys);
    endtask : settle

    task automatic chk_state(input logic [8:0] exp);
        @(negedge clk_sys);
        chk({23'h0, driveEnable, safeState, safetyHealthFlag, terminalOn, display},
            {23'h0, exp});
        @(posedge clk_sys);
    endtask : chk_state

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_defaults();
        chk_state({6'h0, SSM_DISP_NONE});
        rd_chk(ADDR_SEL0, 32'h0, 1'h0);
        rd_chk(ADDR_SEL1, 32'h1, 1'h0);
        rd_chk(ADDR_SEL2, 32'h0, 1'h0);
        rd_chk(12'h020, 32'h0, 1'h1);
    endtask : t_defaults

    task automatic t_no_power();
        runReq <= 1'h1;
        settle();
        chk_state({6'h0, SSM_DISP_NONE});
    endtask : t_no_power

    task automatic t_run();
        powerGood <= 1'h1;
        settle();
        chk_state({3'h5, 3'h5, SSM_DISP_NONE});
        rd_chk(ADDR_STATUS, 32'h7, 1'h0);
        glitchReq <= 1'h1;
        @(posedge clk_sys);
        glitchReq <= 1'h0;
        repeat (FILT + 2) begin
            chk_state({3'h5, 3'h5, SSM_DISP_NONE});
        end
    endtask : t_run

    task automatic t_stop_select();
        runReq <= 1'h0;
        settle();
        chk_state({3'h3, 3'h5, SSM_DISP_STOP_ACTIVE});
        apb(1'h1, ADDR_SEL0, 32'h51);
        apb(1'h1, ADDR_SEL1, 32'h50);
        apb(1'h1, ADDR_SEL2, 32'hb5);
        rd_chk(ADDR_SEL2, 32'hb5, 1'h0);
        chk_state({3'h3, 3'h3, SSM_DISP_STOP_ACTIVE});
    endtask : t_stop_select

    // Mismatch latches; only a clear with the cause gone restores drive
    task automatic t_mismatch();
        runReq <= 1'h1;
        splitReq <= 1'h1;
        settle();
        chk_state({3'h0, 3'h4, SSM_DISP_FAULT_7});
        rd_chk(ADDR_STATUS, 32'h4d, 1'h0);
        splitReq <= 1'h0;
        settle();
        chk_state({3'h0, 3'h4, SSM_DISP_SAFETY_FAULT});
        apb(1'h1, ADDR_SEL2, 32'hb4);
        apb(1'h1, ADDR_CTRL, 32'h2);
        chk_state({3'h5, 3'h5, SSM_DISP_NONE});
    endtask : t_mismatch

    task automatic t_faults();
        apb(1'h1, ADDR_CTRL, 32'h1);
        chk_state({3'h0, 3'h4, SSM_DISP_FAULT_6});
        apb(1'h1, ADDR_CTRL, 32'h0);
        apb(1'h1, ADDR_CTRL, 32'h2);
        internalFault <= 1'h1;
        settle();
        chk_state({3'h0, 3'h4, SSM_DISP_FAULT_CPU});
        internalFault <= 1'h0;
        settle();
        apb(1'h1, ADDR_CTRL, 32'h2);
        chk_state({3'h5, 3'h5, SSM_DISP_NONE});
    endtask : t_faults

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'h1;
        @(posedge clk_sys);
        t_defaults();
        t_no_power();
        t_run();
        t_stop_select();
        t_mismatch();
        t_faults();
        results();
    end

    initial begin
        #100000;
        numErrors++;
        results();
    end
endmodule : tb_top
